// file: hw/asl_uart.sv
// single-channel async serial transceiver with its register file
// assumes: one-cycle read/write strobes synchronous to i_clk, pins synchronous
// Function
// - source register: bits 2:1 priority, 7:3 zero
// - format bits 1:0 pick five to eight bits
// - bit 2 gives 1, 1.5 or 2 stops
// - bit 3 adds and checks parity
// - bit 4 clear odd, set even parity
// - bit 5 forces parity to inverse bit 4
// - bit 6 holds serial output low
// - bit 7 maps addresses 0,1 to divisor
// - divisor written as low and high byte
// - control bits 0-3 drive pins low outside loopback, 5-7 zero
// - loopback: output high unless bit 6 set, internal wrap
// - loopback modem events come from control bits
// - data ready while receive data held
// - overrun, parity, framing flags per character
// - break flag on low whole frame
// - holding empty flag shows transmit space
// - shifter empty flag; status bit 7 zero
// - handshake change bits; cleared by read
// - ring change only on pin rising
// - status high nibble mirrors inverted inputs, control bits in loopback
// - free 8-bit scratch register
// - divisor sets the 16x tick rate
// - reset: pins high, mask clear, none pending
// - source bit 0 low while pending
// - priority: line, data, transmit, modem
// - start bit checked on the 8th tick
`include "asl_regs.svh"

module asl_uart
    import asl_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [2:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    output logic o_int,
    input wire logic i_serial_in,
    output logic o_serial_out,
    output logic o_term_ready_n,
    output logic o_send_req_n,
    output logic o_user_out1_n,
    output logic o_user_out2_n,
    input wire logic i_clear_to_send_n,
    input wire logic i_set_ready_n,
    input wire logic i_bell_detect_n,
    input wire logic i_carrier_detect_n
);

    // =================================================================
    // helpers
    function automatic logic par_bit(input logic [7:0] data, input logic [7:0] frame_format);
        logic x;
        x = ^(data & (8'hFF >> (2'h3 - frame_format[1:0])));
        if (frame_format[`ASL_LCR_STICK])
            par_bit = ~frame_format[`ASL_LCR_EPS];
        else
            par_bit = frame_format[`ASL_LCR_EPS] ? x : ~x;
    endfunction

    function automatic logic [7:0] lsr_val(input asl_state_t s);
        logic thre;
        thre = ~s.thr_full;
        lsr_val = {1'b0, thre && s.tx_st == TX_IDLE, thre, s.err, s.cnt != 2'h0};
    endfunction

    function automatic logic [7:0] isr_val(input asl_state_t s);
        if (s.irq_mask_reg[`ASL_IER_LS] && s.err != 4'h0)
            isr_val = `ASL_ISR_LS;
        else if (s.irq_mask_reg[`ASL_IER_RD] && s.cnt != 2'h0)
            isr_val = `ASL_ISR_RD;
        else if (s.irq_mask_reg[`ASL_IER_TX] && !s.thr_full)
            isr_val = `ASL_ISR_TX;
        else if (s.irq_mask_reg[`ASL_IER_MS] && s.mdelta != 4'h0)
            isr_val = `ASL_ISR_MS;
        else
            isr_val = `ASL_ISR_NONE;
    endfunction

    localparam asl_state_t RST = '{div: `ASL_DIV_RESET, tx_line: 1'b1, rx_prev: 1'b1, serial_out: 1'b1,
                                   ctl_n: 4'hF, tx_st: TX_IDLE, rx_st: RX_IDLE, default: '0};

    asl_state_t q;
    asl_state_t d;
    logic tick;
    logic loop;
    logic divisor_access_select;
    logic rx_in;
    logic push;
    logic pop;
    logic [3:0] lvl;
    logic [2:0] last_bit;
    logic [4:0] stop_end;
    logic [7:0] rx_data;
    logic [7:0] isr_next;

    // =================================================================
    // next state
    always_comb begin
        d = q;
        loop = q.handshake_control[`ASL_MCR_LOOP];
        divisor_access_select = q.frame_format[`ASL_LCR_DIVISOR_ACCESS_SELECT];
        last_bit = 3'h4 + {1'b0, q.frame_format[1:0]};
        if (!q.frame_format[`ASL_LCR_STB])
            stop_end = `ASL_BIT_END;
        else if (q.frame_format[1:0] == 2'h0)
            stop_end = `ASL_STOP15_END;
        else
            stop_end = `ASL_STOP2_END;
        rx_in = loop ? q.tx_line : i_serial_in;
        rx_data = q.rsr >> (2'h3 - q.frame_format[1:0]);
        push = 1'b0;
        pop = 1'b0;

        // 16x tick; divisor 0 behaves as 1
        tick = ({1'b0, q.bcnt} + 17'h00001) >= {1'b0, q.div};
        d.bcnt = tick ? 16'h0000 : q.bcnt + 16'h0001;

        // register writes
        if (i_wr) begin
            if (i_addr == `ASL_ADR_DATA && divisor_access_select)
                d.div[7:0] = i_wdata;
            else if (i_addr == `ASL_ADR_DATA && !q.thr_full) begin
                d.thr = i_wdata; // write while full is dropped
                d.thr_full = 1'b1;
            end else if (i_addr == `ASL_ADR_IER && divisor_access_select)
                d.div[15:8] = i_wdata;
            else if (i_addr == `ASL_ADR_IER)
                d.irq_mask_reg = i_wdata[3:0];
            else if (i_addr == `ASL_ADR_LCR)
                d.frame_format = i_wdata;
            else if (i_addr == `ASL_ADR_MCR)
                d.handshake_control = i_wdata[4:0];
            else if (i_addr == `ASL_ADR_SCR)
                d.scr = i_wdata;
        end

        // register reads; clears come before the sets below so a set wins
        if (i_rd) begin
            if (i_addr == `ASL_ADR_DATA && divisor_access_select)
                d.rdata = q.div[7:0];
            else if (i_addr == `ASL_ADR_DATA) begin
                d.rdata = q.fifo[q.rp];
                pop = q.cnt != 2'h0;
            end else if (i_addr == `ASL_ADR_IER)
                d.rdata = divisor_access_select ? q.div[15:8] : {4'h0, q.irq_mask_reg};
            else if (i_addr == `ASL_ADR_ISR)
                d.rdata = isr_val(q);
            else if (i_addr == `ASL_ADR_LCR)
                d.rdata = q.frame_format;
            else if (i_addr == `ASL_ADR_MCR)
                d.rdata = {3'h0, q.handshake_control};
            else if (i_addr == `ASL_ADR_LSR) begin
                d.rdata = lsr_val(q);
                d.err = 4'h0;
            end else if (i_addr == `ASL_ADR_MSR) begin
                d.rdata = {q.mlvl, q.mdelta};
                d.mdelta = 4'h0;
            end else
                d.rdata = q.scr;
        end

        // handshake levels: cd, ri, dsr, cts
        if (loop)
            lvl = {q.handshake_control[3], q.handshake_control[2], q.handshake_control[0], q.handshake_control[1]};
        else
            lvl = ~{i_carrier_detect_n, i_bell_detect_n, i_set_ready_n, i_clear_to_send_n};
        d.mlvl = lvl;
        // ring change flags only when the pin goes high again
        d.mdelta = d.mdelta | {lvl[3] ^ q.mlvl[3], q.mlvl[2] & ~lvl[2], lvl[1:0] ^ q.mlvl[1:0]};

        // =============================================================
        // transmitter
        case (q.tx_st)
            TX_IDLE: begin
                if (q.thr_full) begin
                    d.tsr = q.thr;
                    d.tpar = par_bit(q.thr, q.frame_format);
                    d.thr_full = 1'b0;
                    d.tx_line = 1'b0;
                    d.ttick = 5'h00;
                    d.tx_st = TX_START;
                end
            end
            TX_START: begin
                if (tick) begin
                    d.ttick = q.ttick + 5'h01;
                    if (q.ttick == `ASL_BIT_END) begin
                        d.ttick = 5'h00;
                        d.tx_line = q.tsr[0];
                        d.tbit = 3'h0;
                        d.tx_st = TX_DATA;
                    end
                end
            end
            TX_DATA: begin
                if (tick) begin
                    d.ttick = q.ttick + 5'h01;
                    if (q.ttick == `ASL_BIT_END) begin
                        d.ttick = 5'h00;
                        d.tsr = q.tsr >> 1;
                        d.tbit = q.tbit + 3'h1;
                        d.tx_line = q.tsr[1];
                        if (q.tbit == last_bit) begin
                            d.tx_line = q.frame_format[`ASL_LCR_PEN] ? q.tpar : 1'b1;
                            d.tx_st = q.frame_format[`ASL_LCR_PEN] ? TX_PAR : TX_STOP;
                        end
                    end
                end
            end
            TX_PAR: begin
                if (tick) begin
                    d.ttick = q.ttick + 5'h01;
                    if (q.ttick == `ASL_BIT_END) begin
                        d.ttick = 5'h00;
                        d.tx_line = 1'b1;
                        d.tx_st = TX_STOP;
                    end
                end
            end
            default: begin
                if (tick) begin
                    d.ttick = q.ttick + 5'h01;
                    if (q.ttick == stop_end) begin
                        d.ttick = 5'h00;
                        d.tx_st = TX_IDLE;
                    end
                end
            end
        endcase

        // =============================================================
        // receiver
        d.rx_prev = rx_in;
        case (q.rx_st)
            RX_IDLE: begin
                if (q.rx_prev && !rx_in) begin
                    d.rtick = 5'h00;
                    d.rx_st = RX_START;
                end
            end
            RX_START: begin
                if (tick) begin
                    d.rtick = q.rtick + 5'h01;
                    if (q.rtick == `ASL_RX_MID) begin
                        d.rtick = 5'h00;
                        d.rbit = 3'h0;
                        d.rzero = 1'b1;
                        d.rx_st = rx_in ? RX_IDLE : RX_DATA;
                    end
                end
            end
            RX_DATA: begin
                if (tick) begin
                    d.rtick = q.rtick + 5'h01;
                    if (q.rtick == `ASL_BIT_END) begin
                        d.rtick = 5'h00;
                        d.rsr = {rx_in, q.rsr[7:1]};
                        d.rzero = q.rzero & ~rx_in;
                        d.rbit = q.rbit + 3'h1;
                        if (q.rbit == last_bit)
                            d.rx_st = q.frame_format[`ASL_LCR_PEN] ? RX_PAR : RX_STOP;
                    end
                end
            end
            RX_PAR: begin
                if (tick) begin
                    d.rtick = q.rtick + 5'h01;
                    if (q.rtick == `ASL_BIT_END) begin
                        d.rtick = 5'h00;
                        d.rpar = rx_in;
                        d.rzero = q.rzero & ~rx_in;
                        d.rx_st = RX_STOP;
                    end
                end
            end
            default: begin
                if (tick) begin
                    d.rtick = q.rtick + 5'h01;
                    if (q.rtick == `ASL_BIT_END) begin
                        d.rtick = 5'h00;
                        d.rx_st = RX_IDLE;
                        d.err[1] = d.err[1] | (q.frame_format[`ASL_LCR_PEN] && q.rpar != par_bit(rx_data, q.frame_format));
                        d.err[2] = d.err[2] | ~rx_in;
                        d.err[3] = d.err[3] | (q.rzero & ~rx_in);
                        // buffer full with no read this cycle: word lost
                        if (q.cnt == `ASL_FIFO_FULL && !pop)
                            d.err[0] = 1'b1;
                        else
                            push = 1'b1;
                    end
                end
            end
        endcase

        // two-entry receive buffer
        if (push) begin
            d.fifo[q.wp] = rx_data;
            d.wp = ~q.wp;
        end
        if (pop)
            d.rp = ~q.rp;
        d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};

        // pins straight from the next state
        if (d.frame_format[`ASL_LCR_BRK])
            d.serial_out = 1'b0;
        else
            d.serial_out = d.handshake_control[`ASL_MCR_LOOP] | d.tx_line;
        // looped control bits stay internal, pins idle high
        d.ctl_n = d.handshake_control[`ASL_MCR_LOOP] ? 4'hF : ~d.handshake_control[3:0];
        // a function result cannot be bit-selected directly
        isr_next = isr_val(d);
        d.intr = ~isr_next[0];
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst)
            q <= RST;
        else
            q <= d;
    end

    assign o_rdata = q.rdata;
    assign o_int = q.intr;
    assign o_serial_out = q.serial_out;
    assign o_term_ready_n = q.ctl_n[0];
    assign o_send_req_n = q.ctl_n[1];
    assign o_user_out1_n = q.ctl_n[2];
    assign o_user_out2_n = q.ctl_n[3];

    // =================================================================
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    a_isr_high_zero: assert property (i_rd && i_addr == `ASL_ADR_ISR |=> o_rdata[7:3] == 5'h00)
        else $error("isr upper bits not zero");
    a_break_low: assert property (q.frame_format[`ASL_LCR_BRK] |-> !o_serial_out)
        else $error("break not driving low");
    a_loop_mark: assert property (loop && !q.frame_format[`ASL_LCR_BRK] |-> o_serial_out)
        else $error("loopback output not high");
    a_ctl_pins: assert property (!loop |-> o_send_req_n == !q.handshake_control[1] && o_term_ready_n == !q.handshake_control[0])
        else $error("control pin mismatch");
    a_dr_read: assert property (i_rd && i_addr == `ASL_ADR_LSR |=> o_rdata[0] == ($past(q.cnt) != 2'h0))
        else $error("data ready wrong");
    a_lsr_shape: assert property (i_rd && i_addr == `ASL_ADR_LSR |=> !o_rdata[7] && (!o_rdata[6] || o_rdata[5]))
        else $error("lsr bit 7 or empty flags wrong");
    a_msr_clear: assert property (i_rd && i_addr == `ASL_ADR_MSR && lvl == q.mlvl |=> q.mdelta == 4'h0)
        else $error("modem deltas not cleared");
    a_ring_edge: assert property (q.mlvl[2] && !lvl[2] |=> q.mdelta[2])
        else $error("ring end not flagged");
    a_ring_only: assert property (!q.mlvl[2] && lvl[2] && !q.mdelta[2] |=> !q.mdelta[2])
        else $error("ring flagged on wrong edge");
    a_line_prio: assert property (i_rd && i_addr == `ASL_ADR_ISR && q.irq_mask_reg[`ASL_IER_LS] && q.err != 4'h0
                                  |=> o_rdata[2:0] == 3'h6)
        else $error("line status not top priority");
    a_int_pin: assert property (o_int == (isr_val(q) != `ASL_ISR_NONE))
        else $error("interrupt pin disagrees with source");
    a_start_mid: assert property (q.rx_st == RX_START && tick && q.rtick == `ASL_RX_MID && rx_in
                                  |=> q.rx_st == RX_IDLE)
        else $error("false start accepted");

    c_loop: cover property (loop ##1 q.cnt != 2'h0);
    c_overrun: cover property (q.err[0]);
    c_break: cover property (q.err[3]);
    c_full: cover property (q.cnt == `ASL_FIFO_FULL);

endmodule

// file: common/asl_regs.svh
// register offsets, field positions, reset values and bit timing counts
// assumes: included by the design file only, bare name
`ifndef ASL_REGS_SVH
`define ASL_REGS_SVH

// =====================================================================
// register offsets (3-bit address)
`define ASL_ADR_DATA 3'h0
`define ASL_ADR_IER 3'h1
`define ASL_ADR_ISR 3'h2
`define ASL_ADR_LCR 3'h3
`define ASL_ADR_MCR 3'h4
`define ASL_ADR_LSR 3'h5
`define ASL_ADR_MSR 3'h6
`define ASL_ADR_SCR 3'h7

// =====================================================================
// field positions
`define ASL_LCR_STB 2
`define ASL_LCR_PEN 3
`define ASL_LCR_EPS 4
`define ASL_LCR_STICK 5
`define ASL_LCR_BRK 6
`define ASL_LCR_DIVISOR_ACCESS_SELECT 7
`define ASL_MCR_LOOP 4
`define ASL_IER_RD 0
`define ASL_IER_TX 1
`define ASL_IER_LS 2
`define ASL_IER_MS 3

// =====================================================================
// interrupt source codes, bit 0 high means nothing pending
`define ASL_ISR_NONE 8'h01
`define ASL_ISR_LS 8'h06
`define ASL_ISR_RD 8'h04
`define ASL_ISR_TX 8'h02
`define ASL_ISR_MS 8'h00

// =====================================================================
// reset values, counts in 16x ticks and the receive buffer full level
`define ASL_DIV_RESET 16'h000C
`define ASL_BIT_END 5'h0F
`define ASL_STOP15_END 5'h17
`define ASL_STOP2_END 5'h1F
`define ASL_RX_MID 5'h07
`define ASL_FIFO_FULL 2'h2

`endif

// file: common/asl_pkg.sv
// types of the serial line block: state enums and the state record
// assumes: compiled before hw/asl_uart.sv
package asl_pkg;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} asl_tx_st_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} asl_rx_st_t;

    typedef struct packed {
        logic [7:0] frame_format;
        logic [3:0] irq_mask_reg;
        logic [4:0] handshake_control;
        logic [7:0] scr;
        logic [15:0] div;
        logic [15:0] bcnt;
        asl_tx_st_t tx_st;
        logic [7:0] thr;
        logic thr_full;
        logic [7:0] tsr;
        logic tpar;
        logic [2:0] tbit;
        logic [4:0] ttick;
        logic tx_line;
        asl_rx_st_t rx_st;
        logic rx_prev;
        logic [7:0] rsr;
        logic rpar;
        logic rzero;
        logic [2:0] rbit;
        logic [4:0] rtick;
        logic [1:0][7:0] fifo;
        logic wp;
        logic rp;
        logic [1:0] cnt;
        logic [3:0] err;
        logic [3:0] mlvl;
        logic [3:0] mdelta;
        logic [7:0] rdata;
        logic intr;
        logic serial_out;
        logic [3:0] ctl_n;
    } asl_state_t;

endpackage

// file: tb/asl_line_partner.sv
// far-side terminal model: sends raw line frames, captures 8-bit frames
// assumes: design divisor set to 1, so one bit lasts 16 cycles of i_clk
module asl_line_partner (
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [11:0] i_frame,
    input wire logic [3:0] i_nbits,
    input wire logic i_line_from_dev,
    output logic o_line_to_dev,
    output logic [7:0] o_byte,
    output logic [7:0] o_cnt
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int BIT_CYC = 16;

    initial begin
        o_line_to_dev = 1'b1;
        o_byte = 8'h00;
        o_cnt = 8'h00;
    end

    // ==========================================================
    // sender: raw bits lsb first, so tests can shape bad frames
    always @(posedge i_clk) begin
        if (i_go) begin
            for (int k = 0; k < int'(i_nbits); k++) begin
                o_line_to_dev <= i_frame[k];
                repeat (BIT_CYC) @(posedge i_clk);
            end
            o_line_to_dev <= 1'b1;
        end
    end

    // ==========================================================
    // receiver: mid-bit sampling, noise spikes are dropped
    always begin
        @(negedge i_line_from_dev);
        repeat (BIT_CYC / 2) @(posedge i_clk);
        if (i_line_from_dev == 1'b0) begin
            for (int k = 0; k < 8; k++) begin
                repeat (BIT_CYC) @(posedge i_clk);
                o_byte[k] <= i_line_from_dev;
            end
            repeat (BIT_CYC) @(posedge i_clk);
            o_cnt <= o_cnt + 8'h01;
        end
    end
endmodule

// file: tb/testbench.sv
// self-checking bench: register accesses, line frames via the partner
// assumes: design and partner compiled before, divisor 1 used for speed
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic irq;
    logic serial_in;
    logic serial_out;
    logic [3:0] ctl_n;
    logic [3:0] hs_n = 4'hF;
    logic go = 1'b0;
    logic [11:0] frame = 12'hFFF;
    logic [3:0] nbits = 4'h0;
    logic [7:0] p_byte;
    logic [7:0] p_cnt;
    logic [7:0] d;
    int mismatches = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [7:0] par_lcr [4] = '{8'h1B, 8'h0B, 8'h2B, 8'h3B};
    logic [7:0] par_lsr [4] = '{8'h65, 8'h61, 8'h65, 8'h61};

    always #5 clk = ~clk;

    asl_uart dut_u (
        .i_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wr(wr_s), .i_rd(rd_s),
        .i_wdata(wdata), .o_rdata(rdata), .o_int(irq), .i_serial_in(serial_in), .o_serial_out(serial_out),
        .o_term_ready_n(ctl_n[0]), .o_send_req_n(ctl_n[1]), .o_user_out1_n(ctl_n[2]),
        .o_user_out2_n(ctl_n[3]), .i_clear_to_send_n(hs_n[0]), .i_set_ready_n(hs_n[1]),
        .i_bell_detect_n(hs_n[2]), .i_carrier_detect_n(hs_n[3])
    );

    asl_line_partner far_u (
        .i_clk(clk), .i_go(go), .i_frame(frame), .i_nbits(nbits), .i_line_from_dev(serial_out),
        .o_line_to_dev(serial_in), .o_byte(p_byte), .o_cnt(p_cnt)
    );

    // ==========================================================
    // tasks
    task automatic conclude();
        if (mismatches == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        #1;
        addr = a;
        wdata = v;
        wr_s = 1'b1;
        @(posedge clk);
        #1;
        wr_s = 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        #1;
        addr = a;
        rd_s = 1'b1;
        @(posedge clk);
        #1;
        rd_s = 1'b0;
        v = rdata;
    endtask

    task automatic rchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        chk(v & m, e);
    endtask

    // the partner ignores a go while busy, so wait out the frame here
    task automatic send(input logic [11:0] f, input logic [3:0] n);
        @(posedge clk);
        #1;
        go = 1'b1;
        frame = f;
        nbits = n;
        @(posedge clk);
        #1;
        go = 1'b0;
        repeat (int'(n) * 16) @(posedge clk);
    endtask

    task automatic wait_int();
        for (int n = 0; n < 800 && irq !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk({7'h00, irq}, 8'h01);
    endtask

    task automatic wait_cnt(input logic [7:0] t, input logic [7:0] e);
        for (int n = 0; n < 400 && p_cnt !== t; n++) begin
            @(posedge clk);
            #1;
        end
        chk(p_byte, e);
    endtask

    task automatic pin(input int i, input logic v);
        hs_n[i] = v;
        repeat (3) @(posedge clk);
        #1;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            conclude();
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        #1;
        rst = 1'b0;
        rchk(3'h2, 8'hFF, 8'h01);
        rchk(3'h1, 8'hFF, 8'h00);
        rchk(3'h5, 8'hFF, 8'h60);
        rchk(3'h6, 8'hFF, 8'h00);
        chk({3'h0, serial_out, ctl_n}, 8'h1F);
        wr(3'h7, 8'hA5);
        rchk(3'h7, 8'hFF, 8'hA5);
        wr(3'h1, 8'h0A);
        wr(3'h3, 8'h80);
        wr(3'h0, 8'h01);
        wr(3'h1, 8'h00);
        rchk(3'h0, 8'hFF, 8'h01);
        rchk(3'h1, 8'hFF, 8'h00);
        wr(3'h3, 8'h03);
        rchk(3'h1, 8'hFF, 8'h0A);
        rchk(3'h2, 8'hFF, 8'h02);
        chk({7'h00, irq}, 8'h01);
        wr(3'h4, 8'hEF);
        rchk(3'h4, 8'hFF, 8'h0F);
        chk({3'h0, serial_out, ctl_n}, 8'h10);
        wr(3'h4, 8'h1F);
        chk({3'h0, serial_out, ctl_n}, 8'h1F);
        rchk(3'h6, 8'hFF, 8'hFB);
        pin(0, 1'b0);
        rchk(3'h6, 8'hFF, 8'hF0);
        pin(0, 1'b1);
        wr(3'h4, 8'h10);
        rchk(3'h6, 8'hFF, 8'h0F);
        wr(3'h1, 8'h01);
        // every word length wrapped through loopback
        for (int l = 0; l < 4; l++) begin
            wr(3'h3, 8'(l));
            wr(3'h0, 8'hFF);
            wait_int();
            chk({7'h00, serial_out}, 8'h01);
            rchk(3'h0, 8'hFF, 8'hFF >> (3 - l));
        end
        wr(3'h4, 8'h00);
        rd(3'h6, d);
        pin(2, 1'b0);
        rchk(3'h6, 8'hFF, 8'h40);
        pin(2, 1'b1);
        rchk(3'h6, 8'hFF, 8'h04);
        pin(0, 1'b0);
        rchk(3'h6, 8'hFF, 8'h11);
        pin(0, 1'b1);
        rchk(3'h6, 8'hFF, 8'h01);
        wr(3'h3, 8'h03);
        wr(3'h1, 8'h00);
        wr(3'h0, 8'hA5);
        repeat (4) @(posedge clk);
        wr(3'h0, 8'h5A);
        rchk(3'h5, 8'hFF, 8'h00);
        wait_cnt(8'h01, 8'hA5);
        wait_cnt(8'h02, 8'h5A);
        repeat (40) @(posedge clk);
        rchk(3'h5, 8'hFF, 8'h60);
        wr(3'h1, 8'h01);
        send({2'b11, 8'h3C, 1'b0}, 4'd10);
        wait_int();
        rchk(3'h2, 8'hFF, 8'h04);
        rchk(3'h5, 8'hFF, 8'h61);
        rchk(3'h0, 8'hFF, 8'h3C);
        rchk(3'h5, 8'hFF, 8'h60);
        wr(3'h1, 8'h05);
        // parity bit always sent as zero: even, odd, forced one, forced zero
        for (int i = 0; i < 4; i++) begin
            wr(3'h3, par_lcr[i]);
            send({2'b10, 8'h01, 1'b0}, 4'd11);
            wait_int();
            rchk(3'h2, 8'hFF, (par_lsr[i] == 8'h65) ? 8'h06 : 8'h04);
            rchk(3'h5, 8'hFF, par_lsr[i]);
            rchk(3'h0, 8'hFF, 8'h01);
        end
        wr(3'h3, 8'h03);
        send({2'b00, 8'hFF, 1'b0}, 4'd10);
        wait_int();
        rchk(3'h5, 8'hFF, 8'h69);
        rchk(3'h0, 8'hFF, 8'hFF);
        send(12'h000, 4'd12);
        wait_int();
        rchk(3'h5, 8'h11, 8'h11);
        rchk(3'h0, 8'hFF, 8'h00);
        rd(3'h5, d);
        send({2'b11, 8'h11, 1'b0}, 4'd10);
        send({2'b11, 8'h22, 1'b0}, 4'd10);
        send({2'b11, 8'h33, 1'b0}, 4'd10);
        repeat (20) @(posedge clk);
        rchk(3'h5, 8'h03, 8'h03);
        rchk(3'h0, 8'hFF, 8'h11);
        rchk(3'h0, 8'hFF, 8'h22);
        wr(3'h3, 8'h43);
        repeat (2) @(posedge clk);
        chk({7'h00, serial_out}, 8'h00);
        wr(3'h3, 8'h03);
        repeat (2) @(posedge clk);
        chk({7'h00, serial_out}, 8'h01);
        conclude();
    end
endmodule
